// ### rtl/sgp_pkg.sv
`default_nettype none
package sgp_pkg;

	// ****************************************************************
	// Sizes
	// ****************************************************************
	localparam int unsigned NUM_PINS = 3;
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 32;

	// ****************************************************************
	// Register offsets (byte addresses)
	// ****************************************************************
	localparam logic [7:0] ADDR_PIN_CONFIG = 8'h00;
	localparam logic [7:0] ADDR_BACKUP_STATUS = 8'h04;
	localparam logic [7:0] ADDR_BACKUP_CONTROL = 8'h08;

	// ****************************************************************
	// Field positions
	// ****************************************************************
	localparam int unsigned CFG_EN_LSB = 0;
	localparam int unsigned CFG_OUT_LSB = 4;
	localparam int unsigned CFG_SEL_LSB = 8;
	localparam int unsigned STAT_IN_LSB = 0;
	localparam int unsigned STAT_BACKUP_FAULT_BIT = 4;
	localparam int unsigned STAT_CHARGE_FAULT_BIT = 5;
	localparam int unsigned STAT_HOSTLESS_BIT = 6;
	localparam int unsigned STAT_LEAD_ACID_BIT = 7;
	localparam int unsigned STAT_CHARGE_STATE_LSB = 8;
	localparam int unsigned STAT_TAPER_BIT = 10;
	localparam int unsigned STAT_CAL_DONE_BIT = 11;
	localparam int unsigned CTRL_BACKUP_FAULT_CLEAR_BIT = 0;

	// ****************************************************************
	// Types and reset values
	// ****************************************************************
	typedef struct packed {
		logic [NUM_PINS-1:0] en;
		logic [NUM_PINS-1:0] out;
		logic [NUM_PINS-1:0] status_select;
	} sgp_pin_cfg_s;

	typedef struct packed {
		sgp_pin_cfg_s cfg;
		logic hostless;
		logic lead_acid;
		logic load_pending;
		logic ack;
		logic [DATA_W-1:0] rdata;
	} sgp_main_state_s;

	typedef struct packed {
		logic drive_low;
		logic level;
	} sgp_pin_state_s;

	localparam sgp_pin_cfg_s CFG_RESET = '{en: 3'h0, out: 3'h0, status_select: 3'h0};
	localparam sgp_pin_cfg_s CFG_HOSTLESS = '{en: 3'h7, out: 3'h0, status_select: 3'h7};
	localparam sgp_main_state_s MAIN_RESET = '{cfg: CFG_RESET, hostless: 1'b0, lead_acid: 1'b0,
		load_pending: 1'b1, ack: 1'b0, rdata: 32'h0000_0000};
	localparam sgp_pin_state_s PIN_RESET = '{drive_low: 1'b0, level: 1'b1};

endpackage
`default_nettype wire

// ### rtl/sgp_sticky_flag.sv
`timescale 1ns/100ps
`default_nettype none
module sgp_sticky_flag (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Events
	input wire logic set_i,
	input wire logic clear_i,
	// Flag
	output logic flag_o
);

	logic flag_q;
	logic flag_d;

	// ****************************************************************
	// Sticky flag
	// ****************************************************************
	// The set term is last so an event in the clearing cycle is kept.
	always_comb begin
		flag_d = flag_q;
		if (clear_i) begin
			flag_d = 1'b0;
		end
		if (set_i) begin
			flag_d = 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			flag_q <= 1'b0;
		end else begin
			flag_q <= flag_d;
		end
	end

	assign flag_o = flag_q;

endmodule
`default_nettype wire

// ### rtl/sgp_pin_cell.sv
`timescale 1ns/100ps
`default_nettype none
module sgp_pin_cell (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Configuration
	input wire logic en_i,
	input wire logic out_i,
	input wire logic status_select_i,
	input wire logic status_true_i,
	// Pad
	input wire logic pin_i,
	output logic pin_o,
	output logic pin_oe_n_o,
	// Sampled level
	output logic level_o
);

	sgp_pkg::sgp_pin_state_s st_q;
	sgp_pkg::sgp_pin_state_s st_d;

	// ****************************************************************
	// Drive decision
	// ****************************************************************
	always_comb begin
		st_d = st_q;
		st_d.drive_low = 1'b0;
		if (en_i) begin
			if (status_select_i) begin
				st_d.drive_low = status_true_i; // see [RQ4] see [RQ9]
			end else begin
				st_d.drive_low = ~out_i; // see [RQ17] see [RQ19]
			end
		end
		st_d.level = pin_i; // see [RQ7]
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_q <= sgp_pkg::PIN_RESET;
		end else begin
			st_q <= st_d;
		end
	end

	// The pad never sources: it only sinks, otherwise it floats.
	assign pin_o = 1'b0; // see [RQ1]
	assign pin_oe_n_o = ~st_q.drive_low; // see [RQ1]
	assign level_o = st_q.level;

endmodule
`default_nettype wire

// ### rtl/sgp_status_pins.sv
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// [RQ1] Pins only sink current; otherwise they float, never drive high.
// [RQ2] Each pin is independently general purpose or status reporting.
// [RQ3] Pin configuration returns to default only on undervoltage or shutdown.
// [RQ4] In status mode the status signal drives the pin, output bit ignored.
// [RQ5] Mid-level address strap powers up all pins in status mode.
// [RQ6] Hostless mode keeps the bus working; host may rewrite config anytime.
// [RQ7] Every pin level is always sampled and readable as an input bit.
// [RQ8] Software clears enable before reading an externally driven level.
// [RQ9] Five status signals exist; each pulls its pin low while true.
// [RQ10] Charging status is low when either charge state bit is one.
// [RQ11] Taper status exists only for lead-acid and replaces charging status.
// [RQ12] Backup fault pin low while sticky flag set; clear bit resets it.
// [RQ13] Backup fault flag never blocks charging or calibration.
// [RQ14] Charge fault pin low while charge fault flag is one.
// [RQ15] Calibration done pin goes low once calibration succeeds.
// [RQ16] Hostless mode puts charge fault on pin three instead.
// [RQ17] Pin one: enable 0 input; select 1 status; select 0 output bit.
// [RQ18] Taper condition is charge current below 20 percent of bulk.
// [RQ19] Pins two and three decode like pin one with their own sources.
// [RQ20] Hostless power-up forces status sources onto all three pins.
// [RQ21] Otherwise pins reset to input mode with all bits cleared.
module sgp_status_pins (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Straps
	input wire logic address_select_strap_i,
	input wire logic lead_acid_strap_i,
	// Power events
	input wire logic uvlo_i,
	input wire logic shutdown_pin_i,
	// Status sources
	input wire logic charge_state_bit0_i,
	input wire logic charge_state_bit1_i,
	input wire logic taper_reached_i,
	input wire logic backup_fault_event_i,
	input wire logic charge_fault_flag_i,
	input wire logic calibration_done_i,
	// Pads
	input wire logic [2:0] pin_i,
	output logic [2:0] pin_o,
	output logic [2:0] pin_oe_n_o,
	// Flag
	output logic backup_fault_flag_o
);

	sgp_pkg::sgp_main_state_s st_q;
	sgp_pkg::sgp_main_state_s st_d;
	logic req;
	logic write_fire;
	logic cfg_reset;
	logic backup_fault_clear;
	logic backup_fault_flag;
	logic charging_true;
	logic taper_true;
	logic [2:0] status_true;
	logic [2:0] pin_level;
	logic [31:0] status_word;
	logic [31:0] read_word;

	// ****************************************************************
	// Status sources
	// ****************************************************************
	// All sources are "true" levels; the pin cell turns true into a low pad.
	assign charging_true = charge_state_bit0_i | charge_state_bit1_i; // see [RQ10]
	// The comparator tripping below 20 percent of bulk current arrives as taper_reached_i.
	assign taper_true = taper_reached_i; // see [RQ18]

	always_comb begin
		status_true[0] = st_q.lead_acid ? taper_true : charging_true; // see [RQ11] see [RQ20]
		status_true[1] = backup_fault_flag; // see [RQ12] see [RQ19]
		// A hostless system never starts calibration, so charge fault is shown.
		if (st_q.hostless) begin
			status_true[2] = charge_fault_flag_i; // see [RQ16] see [RQ14]
		end else begin
			status_true[2] = calibration_done_i; // see [RQ15]
		end
	end

	// ****************************************************************
	// Backup fault flag
	// ****************************************************************
	// The flag only feeds status; nothing here gates charging with it.
	sgp_sticky_flag u_backup_fault (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.set_i(backup_fault_event_i),
		.clear_i(backup_fault_clear | shutdown_pin_i), // see [RQ12]
		.flag_o(backup_fault_flag)
	); // see [RQ13]

	assign backup_fault_flag_o = backup_fault_flag;

	// ****************************************************************
	// Pin cells
	// ****************************************************************
	for (genvar i = 0; i < sgp_pkg::NUM_PINS; i++) begin : g_pin
		sgp_pin_cell u_cell (
			.clk_i(clk_i),
			.rst_i(rst_i),
			.en_i(st_q.cfg.en[i]),
			.out_i(st_q.cfg.out[i]),
			.status_select_i(st_q.cfg.status_select[i]),
			.status_true_i(status_true[i]),
			.pin_i(pin_i[i]),
			.pin_o(pin_o[i]),
			.pin_oe_n_o(pin_oe_n_o[i]),
			.level_o(pin_level[i])
		); // see [RQ2]
	end

	// ****************************************************************
	// Read data
	// ****************************************************************
	always_comb begin
		status_word = 32'h0000_0000;
		status_word[sgp_pkg::STAT_IN_LSB +: 3] = pin_level; // see [RQ7]
		status_word[sgp_pkg::STAT_BACKUP_FAULT_BIT] = backup_fault_flag;
		status_word[sgp_pkg::STAT_CHARGE_FAULT_BIT] = charge_fault_flag_i;
		status_word[sgp_pkg::STAT_HOSTLESS_BIT] = st_q.hostless;
		status_word[sgp_pkg::STAT_LEAD_ACID_BIT] = st_q.lead_acid;
		status_word[sgp_pkg::STAT_CHARGE_STATE_LSB] = charge_state_bit0_i;
		status_word[sgp_pkg::STAT_CHARGE_STATE_LSB + 1] = charge_state_bit1_i;
		status_word[sgp_pkg::STAT_TAPER_BIT] = taper_reached_i;
		status_word[sgp_pkg::STAT_CAL_DONE_BIT] = calibration_done_i;
	end

	always_comb begin
		read_word = 32'h0000_0000;
		case (wb_adr_i)
			sgp_pkg::ADDR_PIN_CONFIG: begin
				read_word[sgp_pkg::CFG_EN_LSB +: 3] = st_q.cfg.en;
				read_word[sgp_pkg::CFG_OUT_LSB +: 3] = st_q.cfg.out;
				read_word[sgp_pkg::CFG_SEL_LSB +: 3] = st_q.cfg.status_select;
			end
			sgp_pkg::ADDR_BACKUP_STATUS: begin
				read_word = status_word;
			end
			default: begin
				read_word = 32'h0000_0000;
			end
		endcase
	end

	// ****************************************************************
	// Bus and configuration
	// ****************************************************************
	assign req = wb_cyc_i & wb_stb_i;
	// Writes land on the edge where the master sees ack.
	assign write_fire = req & wb_we_i & st_q.ack;
	// Only undervoltage or shutdown (and power-on) restore defaults.
	assign cfg_reset = uvlo_i | shutdown_pin_i; // see [RQ3]
	assign backup_fault_clear = write_fire & (wb_adr_i == sgp_pkg::ADDR_BACKUP_CONTROL) & wb_sel_i[0]
		& wb_dat_i[sgp_pkg::CTRL_BACKUP_FAULT_CLEAR_BIT]; // see [RQ12]

	always_comb begin
		st_d = st_q;
		st_d.ack = 1'b0;
		if (req && !st_q.ack && !st_q.load_pending) begin
			st_d.ack = 1'b1;
			st_d.rdata = read_word;
		end
		// Host writes are honoured in every mode, hostless included.
		if (write_fire && (wb_adr_i == sgp_pkg::ADDR_PIN_CONFIG)) begin // see [RQ6]
			if (wb_sel_i[0]) begin
				st_d.cfg.en = wb_dat_i[sgp_pkg::CFG_EN_LSB +: 3]; // see [RQ2]
				st_d.cfg.out = wb_dat_i[sgp_pkg::CFG_OUT_LSB +: 3];
			end
			if (wb_sel_i[1]) begin
				st_d.cfg.status_select = wb_dat_i[sgp_pkg::CFG_SEL_LSB +: 3];
			end
		end
		// Strap cfg lands one cycle after any reset lifts; hostless and lead_acid are also resampled during undervoltage or shutdown.
		if (st_q.load_pending) begin
			st_d.load_pending = 1'b0;
			st_d.hostless = address_select_strap_i;
			st_d.lead_acid = lead_acid_strap_i;
			if (address_select_strap_i) begin
				st_d.cfg = sgp_pkg::CFG_HOSTLESS; // see [RQ5] see [RQ20]
			end else begin
				st_d.cfg = sgp_pkg::CFG_RESET; // see [RQ21]
			end
		end
		if (cfg_reset) begin
			st_d.cfg = sgp_pkg::CFG_RESET; // see [RQ3]
			st_d.load_pending = 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_q <= sgp_pkg::MAIN_RESET;
		end else begin
			st_q <= st_d;
		end
	end

	assign wb_ack_o = st_q.ack;
	assign wb_dat_o = st_q.rdata;

endmodule
`default_nettype wire

// ### bench/sgp_pullup_model.sv
`timescale 1ns/100ps
`default_nettype none
// Resistor pull-ups on the three pads, plus an outside device that may sink each pad.
// A released pad that the outside device does not sink reads high, never a stale level, because the pull-up decides it.
module sgp_pullup_model (
	// Pad drive from the block
	input wire logic [2:0] pin_o_i,
	input wire logic [2:0] pin_oe_n_i,
	// Outside device sinks
	input wire logic [2:0] ext_low_i,
	// Resolved pad level
	output logic [2:0] level_o
);
	assign level_o = ~ext_low_i & (pin_oe_n_i | pin_o_i);
endmodule
`default_nettype wire

// ### bench/sgp_status_pins_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module sgp_status_pins_monitor (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Bus
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic wb_ack_o,
	// Events and pads
	input wire logic uvlo_i,
	input wire logic shutdown_pin_i,
	input wire logic backup_fault_event_i,
	input wire logic [2:0] pin_o,
	input wire logic [2:0] pin_oe_n_o,
	input wire logic backup_fault_flag_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence s_shd; shutdown_pin_i [*3]; endsequence
	sequence s_uv; uvlo_i [*3]; endsequence
	property p_od; pin_o == 3'h0; endproperty
	a_od: assert property (p_od) else $error("pad driven high");
	property p_shd; s_shd |=> &pin_oe_n_o; endproperty
	a_shd: assert property (p_shd) else $error("pad sinks in shutdown");
	property p_uv; s_uv |=> &pin_oe_n_o; endproperty
	a_uv: assert property (p_uv) else $error("pad sinks in undervoltage");
	property p_set; backup_fault_event_i |=> backup_fault_flag_o; endproperty
	a_set: assert property (p_set) else $error("fault flag not set");
	property p_clr; shutdown_pin_i && !backup_fault_event_i |=> !backup_fault_flag_o; endproperty
	a_clr: assert property (p_clr) else $error("fault flag kept in shutdown");
	property p_sticky;
		$fell(backup_fault_flag_o) |-> $past(shutdown_pin_i) || ($past(wb_ack_o) && $past(wb_we_i));
	endproperty
	a_sticky: assert property (p_sticky) else $error("fault flag fell alone");
	property p_ack; wb_ack_o |-> wb_cyc_i && wb_stb_i ##1 !wb_ack_o; endproperty
	a_ack: assert property (p_ack) else $error("bad acknowledge");
	property p_rst; @(posedge clk_i) disable iff (1'b0) rst_i |=> !wb_ack_o && &pin_oe_n_o; endproperty
	a_rst: assert property (p_rst) else $error("reset state wrong");
endmodule
bind sgp_status_pins sgp_status_pins_monitor mon (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_ack_o(wb_ack_o), .uvlo_i(uvlo_i),
	.shutdown_pin_i(shutdown_pin_i), .backup_fault_event_i(backup_fault_event_i), .pin_o(pin_o),
	.pin_oe_n_o(pin_oe_n_o), .backup_fault_flag_o(backup_fault_flag_o));
`default_nettype wire

// ### bench/sgp_status_pins_bench.sv
`timescale 1ns/100ps
`default_nettype none
module sgp_status_pins_bench;
	logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, hs = 0, la = 0, uv = 0, sd = 0;
	logic cs0 = 0, cs1 = 0, tp = 0, bfe = 0, cf = 0, cal = 0;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'hF;
	logic [31:0] wd = 32'h0000_0000, r, c;
	logic [2:0] ext = 3'h0, lvl, po, oe;
	logic [31:0] rd;
	logic ack, flag;
	integer errors = 0, checks = 0, seed = 32'he272d6f7, k;
	sgp_status_pins dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(rd), .wb_ack_o(ack),
		.address_select_strap_i(hs), .lead_acid_strap_i(la), .uvlo_i(uv), .shutdown_pin_i(sd),
		.charge_state_bit0_i(cs0), .charge_state_bit1_i(cs1), .taper_reached_i(tp),
		.backup_fault_event_i(bfe), .charge_fault_flag_i(cf), .calibration_done_i(cal),
		.pin_i(lvl), .pin_o(po), .pin_oe_n_o(oe), .backup_fault_flag_o(flag));
	sgp_pullup_model pads (.pin_o_i(po), .pin_oe_n_i(oe), .ext_low_i(ext), .level_o(lvl));
	initial begin
		forever #10 clk_i = ~clk_i;
	end
	task wrap_up;
		if (errors == 0 && checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task cmp(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH %0t got %h want %h", $time, got, exp);
		end
	endtask
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		integer n;
		n = 0;
		cyc <= 1; stb <= 1; we <= w; adr <= a; wd <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 50);
		if (n >= 50) cmp(32'h0000_0001, 32'h0000_0000);
		r = rd;
		cyc <= 0; stb <= 0;
		@(posedge clk_i);
	endtask
	task reset;
		rst_i <= 1;
		repeat (10) @(posedge clk_i);
		rst_i <= 0;
		@(posedge clk_i);
	endtask
	task settle;
		repeat (4) @(posedge clk_i);
	endtask
	// Open-drain pads: low only where enabled and either status is selected with its source true, or not selected with the output bit 0.
	function automatic logic [2:0] exp_oe(logic [31:0] g, logic [2:0] st);
		return ~(g[2:0] & ((g[10:8] & st) | (~g[10:8] & ~g[6:4])));
	endfunction
	initial begin
		reset;
		wb(0, 8'h00, 0); cmp(r, 0);
		wb(0, 8'h0C, 0); cmp(r, 0);
		repeat (24) begin
			c = $random(seed) & 32'h777;
			{cal, cf, tp, cs1, cs0} <= $random(seed);
			ext <= $random(seed) & $random(seed);
			wb(1, 8'h00, c);
			settle;
			cmp(oe, exp_oe(c, {cal, 1'b0, cs0 | cs1}));
			cmp(po, 3'h0);
			wb(0, 8'h04, 0);
			cmp(r[5:0], {cf, 2'b00, exp_oe(c, {cal, 1'b0, cs0 | cs1}) & ~ext});
		end
		ext <= 0;
		wb(1, 8'h00, 32'h202);
		bfe <= 1;
		@(posedge clk_i);
		bfe <= 0;
		settle;
		cmp(oe, 3'h5);
		cmp(flag, 1'b1);
		wb(1, 8'h08, 1);
		settle;
		cmp(oe, 3'h7);
		cmp(flag, 1'b0);
		for (k = 0; k < 2; k++) begin
			wb(1, 8'h00, 32'h777);
			uv <= k; sd <= !k;
			settle;
			uv <= 0; sd <= 0;
			@(posedge clk_i);
			wb(0, 8'h00, 0); cmp(r, 0);
		end
		hs <= 1; la <= 1; cf <= 1; cal <= 0; tp <= 1; cs0 <= 1;
		reset;
		wb(0, 8'h00, 0); cmp(r, 32'h707);
		settle;
		cmp(oe[2], 1'b0);
		cmp(oe[0], 1'b0);
		cf <= 0; cal <= 1; tp <= 0;
		settle;
		cmp(oe[2], 1'b1);
		cmp(oe[0], 1'b1);
		wb(1, 8'h00, 0);
		wb(0, 8'h00, 0); cmp(r, 0);
		sel <= 4'h1;
		wb(1, 8'h00, 32'h777);
		sel <= 4'hF;
		wb(0, 8'h00, 0); cmp(r, 32'h077);
		wrap_up;
	end
	initial begin
		repeat (20000) @(posedge clk_i);
		errors++;
		wrap_up;
	end
endmodule
`default_nettype wire
